// ===== core/pmr_regs.sv
`timescale 1ns/1ps
//
// Contract
// RULE_01 - Comm fault bits 7:5 set, maskable
// RULE_02 - Comm fault bits 4:0 read zero
// RULE_03 - Vendor fault bits 7:1 reported, maskable
// RULE_04 - Vendor fault bit 0 reads zero
// RULE_05 - Telemetry: 5-bit exponent, 11-bit mantissa
// RULE_06 - Input voltage exponent fixed at minus five
// RULE_07 - Input current exponent fixed at minus four
// RULE_08 - Some readings acknowledge only while regulating
// RULE_09 - Output voltage: measured, unsigned 16-bit mantissa
// RULE_10 - Output current exponent fixed at minus four
// RULE_11 - Temperature zero exponent, signed mantissa
// RULE_12 - Frequency zero exponent, unsigned kilohertz
// RULE_13 - Protocol revision byte is read-only
// RULE_14 - Protocol revision reads 33 hex
// RULE_15 - Maker block: count one, value high
// RULE_16 - Model, revision, serial blocks likewise
// RULE_17 - Host uses block transfers for these
// RULE_18 - Save-all copies identification bytes out
// RULE_19 - Summary bit one mirrors comm faults
// RULE_20 - Active-low alert driven on faults
// RULE_21 - Unknown command, bad count flag faults
module pmr_regs #(
    parameter logic [7:0] MAKER_INIT = 8'h5a,   // Arbitrary value
    parameter logic [7:0] MODEL_INIT = 8'h01,   // Arbitrary value
    parameter logic [7:0] REV_INIT   = 8'h01,   // Arbitrary value
    parameter logic [7:0] SERIAL_INIT = 8'h00   // Arbitrary value
) (
    input  wire logic              clock_i,
    input  wire logic              reset_n_i,
    input  wire pmr_pkg::pmr_req_t req_i,
    input  wire logic              pec_error_i,
    input  wire logic              clear_faults_i,
    input  wire logic              save_all_i,
    input  wire logic              regulating_i,
    input  wire logic [7:1]        vendor_fault_i,
    input  wire pmr_pkg::pmr_tele_t tele_i,
    output pmr_pkg::pmr_rsp_t      rsp_o,
    output pmr_pkg::pmr_nvm_t      nvm_o,
    output logic                   summary_comm_o,
    output logic                   alert_output_low_o
);
    // Whole state of the block
    typedef struct packed {
        logic              reg_s1;     // Regulating, first stage
        logic              reg_s2;     // Regulating, usable
        logic [7:1]        vf_s1;      // Vendor faults, first stage
        logic [7:1]        vf_s2;      // Vendor faults, usable
        logic [2:0]        comm;       // Sticky comm faults 7:5
        logic [6:0]        vend;       // Sticky vendor faults 7:1
        logic [2:0]        comm_mask;  // Alert mask for comm faults
        logic [6:0]        vend_mask;  // Alert mask for vendor faults
        logic [7:0]        maker;      // Identification bytes
        logic [7:0]        model;
        logic [7:0]        revision;
        logic [7:0]        serial;
        pmr_pkg::pmr_rsp_t rsp;        // Registered answer
        pmr_pkg::pmr_nvm_t nvm;        // Registered save strobe
        logic              alert;      // Registered alert, active high
    } pmr_state_t;

    pmr_state_t state_q;   // Current state
    pmr_state_t state_d;   // Next state

    logic [2:0] comm_set;  // Comm fault events this cycle
    logic       known;     // Command is in the implemented set
    logic       needs_reg; // Reading needs regulation
    logic [7:0] rd_byte;   // Byte read from comm or vendor status

    // Outputs straight from state
    assign rsp_o              = state_q.rsp;
    assign nvm_o              = state_q.nvm;
    // RULE_19 summary from comm bits
    assign summary_comm_o     = |state_q.comm;
    assign alert_output_low_o = ~state_q.alert;

    // Decode, fault capture and answer
    always_comb begin
        state_d   = state_q;
        comm_set  = 3'h0;
        rd_byte   = 8'h00;
        // Two stages before logic looks at the regulating and vendor fault levels
        state_d.reg_s1 = regulating_i;
        state_d.reg_s2 = state_q.reg_s1;
        state_d.vf_s1  = vendor_fault_i;
        state_d.vf_s2  = state_q.vf_s1;
        state_d.rsp    = '0;
        state_d.nvm.valid = 1'b0;

        // Known command codes
        case (req_i.cmd)
            pmr_pkg::CMD_COMM_FAULT, pmr_pkg::CMD_VENDOR_FAULT, pmr_pkg::CMD_VIN,
            pmr_pkg::CMD_IIN, pmr_pkg::CMD_VOUT, pmr_pkg::CMD_IOUT, pmr_pkg::CMD_TEMP,
            pmr_pkg::CMD_FREQ, pmr_pkg::CMD_PROTO_REV, pmr_pkg::CMD_MAKER,
            pmr_pkg::CMD_MODEL, pmr_pkg::CMD_PROD_REV, pmr_pkg::CMD_SERIAL,
            pmr_pkg::CMD_ALERT_MASK: begin
                known = 1'b1;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        // RULE_08 regulation gated reads
        needs_reg = (req_i.cmd == pmr_pkg::CMD_IIN) || (req_i.cmd == pmr_pkg::CMD_VOUT) ||
                    (req_i.cmd == pmr_pkg::CMD_IOUT) || (req_i.cmd == pmr_pkg::CMD_FREQ);

        // PEC failure from the engine
        // RULE_01 packet error flag
        comm_set[pmr_pkg::CF_PEC - 5] = pec_error_i;

        if (req_i.valid) begin
            state_d.rsp.valid = 1'b1;
            if (!known) begin
                // RULE_21 unknown command flagged
                comm_set[pmr_pkg::CF_BAD_CMD - 5] = 1'b1;
            end else if (req_i.write) begin
                case (req_i.cmd)
                    // Block writes: count must be one
                    pmr_pkg::CMD_MAKER, pmr_pkg::CMD_MODEL,
                    pmr_pkg::CMD_PROD_REV, pmr_pkg::CMD_SERIAL: begin
                        if (req_i.count != pmr_pkg::BLOCK_COUNT) begin
                            // RULE_21 bad byte count
                            comm_set[pmr_pkg::CF_BAD_DATA - 5] = 1'b1;
                        end else begin
                            state_d.rsp.ack = 1'b1;
                            // RULE_15 maker byte write
                            if (req_i.cmd == pmr_pkg::CMD_MAKER)    state_d.maker    = req_i.data[15:8];
                            // RULE_16 other block bytes
                            if (req_i.cmd == pmr_pkg::CMD_MODEL)    state_d.model    = req_i.data[15:8];
                            if (req_i.cmd == pmr_pkg::CMD_PROD_REV) state_d.revision = req_i.data[15:8];
                            if (req_i.cmd == pmr_pkg::CMD_SERIAL)   state_d.serial   = req_i.data[15:8];
                        end
                    end
                    // Mask write: low byte names status, high byte is mask
                    pmr_pkg::CMD_ALERT_MASK: begin
                        if (req_i.count != pmr_pkg::WORD_COUNT) begin
                            comm_set[pmr_pkg::CF_BAD_DATA - 5] = 1'b1;
                        end else if (req_i.data[7:0] == pmr_pkg::CMD_COMM_FAULT) begin
                            state_d.rsp.ack = 1'b1;
                            // RULE_02 only bits 7:5 maskable
                            state_d.comm_mask = req_i.data[15:13];
                        end else if (req_i.data[7:0] == pmr_pkg::CMD_VENDOR_FAULT) begin
                            state_d.rsp.ack = 1'b1;
                            // RULE_04 bit 0 has no mask
                            state_d.vend_mask = req_i.data[15:9];
                        end else begin
                            comm_set[pmr_pkg::CF_BAD_DATA - 5] = 1'b1;
                        end
                    end
                    default: begin
                        // RULE_13 read-only codes refuse writes
                        comm_set[pmr_pkg::CF_BAD_CMD - 5] = 1'b1;
                    end
                endcase
            end else if (needs_reg && !state_q.reg_s2) begin
                // RULE_08 no acknowledge when idle
                state_d.rsp.ack = 1'b0;
            end else begin
                state_d.rsp.ack = 1'b1;
                case (req_i.cmd)
                    pmr_pkg::CMD_COMM_FAULT: begin
                        // RULE_02 low bits read zero
                        rd_byte = {state_q.comm, 5'h00};
                        state_d.rsp.data = {8'h00, rd_byte};
                    end
                    pmr_pkg::CMD_VENDOR_FAULT: begin
                        // RULE_04 bit 0 reads zero
                        rd_byte = {state_q.vend, 1'b0};
                        state_d.rsp.data = {8'h00, rd_byte};
                    end
                    // RULE_05 exponent over mantissa
                    // RULE_06 input voltage word
                    pmr_pkg::CMD_VIN:  state_d.rsp.data = {pmr_pkg::EXP_VIN, tele_i.vin};
                    // RULE_07 input current word
                    pmr_pkg::CMD_IIN:  state_d.rsp.data = {pmr_pkg::EXP_CURRENT, tele_i.iin};
                    // RULE_09 measured output voltage
                    pmr_pkg::CMD_VOUT: state_d.rsp.data = tele_i.vout;
                    // RULE_10 output current word
                    pmr_pkg::CMD_IOUT: state_d.rsp.data = {pmr_pkg::EXP_CURRENT, tele_i.iout};
                    // RULE_11 signed temperature word
                    pmr_pkg::CMD_TEMP: state_d.rsp.data = {pmr_pkg::EXP_ZERO, tele_i.temp};
                    // RULE_12 frequency word
                    pmr_pkg::CMD_FREQ: state_d.rsp.data = {pmr_pkg::EXP_ZERO, tele_i.freq};
                    // RULE_14 fixed revision value
                    pmr_pkg::CMD_PROTO_REV: state_d.rsp.data = {8'h00, pmr_pkg::PROTO_REV_VALUE};
                    // RULE_15 count low, value high
                    pmr_pkg::CMD_MAKER:    state_d.rsp.data = {state_q.maker, pmr_pkg::BLOCK_COUNT};
                    // RULE_16 same block layout
                    pmr_pkg::CMD_MODEL:    state_d.rsp.data = {state_q.model, pmr_pkg::BLOCK_COUNT};
                    pmr_pkg::CMD_PROD_REV: state_d.rsp.data = {state_q.revision, pmr_pkg::BLOCK_COUNT};
                    pmr_pkg::CMD_SERIAL:   state_d.rsp.data = {state_q.serial, pmr_pkg::BLOCK_COUNT};
                    default: begin
                        // Mask code reads back nothing useful
                        state_d.rsp.data = 16'h0000;
                    end
                endcase
            end
        end

        // Sticky flags: a set in the clearing cycle wins
        // RULE_01 sticky comm bits
        state_d.comm = ((clear_faults_i ? 3'h0 : state_q.comm)) | comm_set;
        // RULE_03 sticky vendor bits
        state_d.vend = ((clear_faults_i ? 7'h00 : state_q.vend)) | state_q.vf_s2;

        // RULE_18 hand identification bytes to storage
        if (save_all_i) begin
            state_d.nvm = {1'b1, state_q.maker, state_q.model, state_q.revision, state_q.serial};
        end

        // RULE_20 unmasked faults raise alert
        state_d.alert = |(state_q.comm & ~state_q.comm_mask) |
                        |(state_q.vend & ~state_q.vend_mask);
    end

    // State register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q           <= '0;
            state_q.comm      <= pmr_pkg::COMM_RESET;
            state_q.vend      <= pmr_pkg::VEND_RESET;
            state_q.maker     <= MAKER_INIT;
            state_q.model     <= MODEL_INIT;
            state_q.revision  <= REV_INIT;
            state_q.serial    <= SERIAL_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_unknown_cmd_flag: assert property ( // RULE_21
        req_i.valid && !known |=> state_q.comm[2] && !state_q.rsp.ack)
        else $error("Unknown command not flagged");
    a_pec_flag_set: assert property ( // RULE_01
        pec_error_i |=> state_q.comm[0])
        else $error("Packet error not flagged");
    a_idle_read_nack: assert property ( // RULE_08
        req_i.valid && !req_i.write && needs_reg && !state_q.reg_s2 |=> !rsp_o.ack)
        else $error("Read acknowledged while not regulating");
    a_revision_value: assert property ( // RULE_14
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_PROTO_REV
        |=> rsp_o.ack && rsp_o.data == 16'h0033)
        else $error("Revision byte wrong");
    a_vin_exponent: assert property ( // RULE_06
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_VIN
        |=> rsp_o.data[15:11] == 5'h1b)
        else $error("Input voltage exponent wrong");
    a_block_count_one: assert property ( // RULE_15
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_MAKER
        |=> rsp_o.data[7:0] == 8'h01 && rsp_o.data[15:8] == $past(state_q.maker))
        else $error("Block read layout wrong");
    a_comm_low_zero: assert property ( // RULE_02
        rsp_o.valid && $past(req_i.cmd) == pmr_pkg::CMD_COMM_FAULT && !$past(req_i.write)
        |-> rsp_o.data[4:0] == 5'h00)
        else $error("Comm fault low bits not zero");
    a_alert_follows: assert property ( // RULE_20
        |(state_q.vend & ~state_q.vend_mask) |=> !alert_output_low_o)
        else $error("Alert not driven");
    a_save_copies: assert property ( // RULE_18
        save_all_i |=> nvm_o.valid && nvm_o.serial == $past(state_q.serial))
        else $error("Save did not copy bytes");
    a_summary_bit: assert property ( // RULE_19
        pec_error_i ##1 !clear_faults_i |-> summary_comm_o ##1 summary_comm_o)
        else $error("Summary bit not set");

    // RULE_01 set beats clear
    a_pec_beats_clear: assert property ( // RULE_01
        pec_error_i && clear_faults_i |=> state_q.comm[0] && summary_comm_o)
        else $error("Clear won over packet error");
    // RULE_01 masked faults stay quiet
    a_alert_quiet: assert property ( // RULE_01
        !(|(state_q.comm & ~state_q.comm_mask)) && !(|(state_q.vend & ~state_q.vend_mask))
        |=> alert_output_low_o)
        else $error("Alert driven with every fault masked");
    // RULE_03 vendor levels latch
    a_vend_sticky: assert property ( // RULE_03
        state_q.vf_s2 != 7'h00
        |=> (state_q.vend & $past(state_q.vf_s2)) == $past(state_q.vf_s2))
        else $error("Vendor fault not latched");
    // RULE_04 vendor bit zero clear
    a_vend_low_zero: assert property ( // RULE_04
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_VENDOR_FAULT
        |=> rsp_o.data[0] == 1'b0 && rsp_o.data[15:8] == 8'h00)
        else $error("Vendor status unused bits not zero");
    // RULE_05 mantissa passes through
    a_vin_mantissa: assert property ( // RULE_05
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_VIN
        |=> rsp_o.data[10:0] == $past(tele_i.vin))
        else $error("Input voltage mantissa wrong");
    // RULE_07 input current exponent
    a_iin_exponent: assert property ( // RULE_07
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_IIN && state_q.reg_s2
        |=> rsp_o.ack && rsp_o.data[15:11] == 5'h1c)
        else $error("Input current exponent wrong");
    // RULE_09 measured output voltage
    a_vout_measured: assert property ( // RULE_09
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_VOUT && state_q.reg_s2
        |=> rsp_o.ack && rsp_o.data == $past(tele_i.vout))
        else $error("Output voltage not the measured value");
    // RULE_10 output current exponent
    a_iout_exponent: assert property ( // RULE_10
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_IOUT && state_q.reg_s2
        |=> rsp_o.ack && rsp_o.data[15:11] == 5'h1c)
        else $error("Output current exponent wrong");
    // RULE_11 temperature zero exponent
    a_temp_exponent: assert property ( // RULE_11
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_TEMP
        |=> rsp_o.ack && rsp_o.data == {5'h00, $past(tele_i.temp)})
        else $error("Temperature word wrong");
    // RULE_12 frequency zero exponent
    a_freq_exponent: assert property ( // RULE_12
        req_i.valid && !req_i.write && req_i.cmd == pmr_pkg::CMD_FREQ && state_q.reg_s2
        |=> rsp_o.ack && rsp_o.data[15:11] == 5'h00)
        else $error("Frequency exponent wrong");
    // RULE_13 revision byte refuses writes
    a_rev_write_refused: assert property ( // RULE_13
        req_i.valid && req_i.write && req_i.cmd == pmr_pkg::CMD_PROTO_REV
        |=> !rsp_o.ack && state_q.comm[2])
        else $error("Revision byte write not refused");
    // RULE_16 model byte write lands
    a_model_write: assert property ( // RULE_16
        req_i.valid && req_i.write && req_i.cmd == pmr_pkg::CMD_MODEL && req_i.count == 8'h01
        |=> rsp_o.ack && {state_q.model, 8'h00} == ($past(req_i.data) & 16'hff00))
        else $error("Model byte write lost");
    // RULE_21 bad count flagged
    a_bad_count_flag: assert property ( // RULE_21
        req_i.valid && req_i.write && req_i.cmd == pmr_pkg::CMD_MAKER && req_i.count != 8'h01
        |=> !rsp_o.ack && state_q.comm[1])
        else $error("Bad byte count not flagged");
    // RULE_20 unmasked comm raises alert
    a_comm_alert: assert property ( // RULE_20
        |(state_q.comm & ~state_q.comm_mask) |=> !alert_output_low_o)
        else $error("Alert not driven on comm fault");
    // RULE_08 no answer without request
    a_answer_pulse: assert property ( // RULE_08
        !req_i.valid |=> !rsp_o.valid && !rsp_o.ack)
        else $error("Answer without a request");
    // RULE_18 no stray save strobe
    a_save_idle: assert property ( // RULE_18
        !save_all_i |=> !nvm_o.valid)
        else $error("Save strobe without save command");
endmodule : pmr_regs

// ===== include/pmr_pkg.sv
package pmr_pkg;
    // Command codes of the registers this block answers
    localparam logic [7:0] CMD_COMM_FAULT    = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_FAULT  = 8'h80;
    localparam logic [7:0] CMD_VIN           = 8'h88;
    localparam logic [7:0] CMD_IIN           = 8'h89;
    localparam logic [7:0] CMD_VOUT          = 8'h8b;
    localparam logic [7:0] CMD_IOUT          = 8'h8c;
    localparam logic [7:0] CMD_TEMP          = 8'h8d;
    localparam logic [7:0] CMD_FREQ          = 8'h95;
    localparam logic [7:0] CMD_PROTO_REV     = 8'h98;
    localparam logic [7:0] CMD_MAKER         = 8'h99;
    localparam logic [7:0] CMD_MODEL         = 8'h9a;
    localparam logic [7:0] CMD_PROD_REV      = 8'h9b;
    localparam logic [7:0] CMD_SERIAL        = 8'h9e;
    // Alert mask command code
    localparam logic [7:0] CMD_ALERT_MASK    = 8'h1b;

    // Fixed exponents of the telemetry words
    localparam logic [4:0] EXP_VIN           = 5'h1b;
    localparam logic [4:0] EXP_CURRENT       = 5'h1c;
    localparam logic [4:0] EXP_ZERO          = 5'h00;
    localparam int         MANT_W            = 11;

    // Protocol revision read back value
    localparam logic [7:0] PROTO_REV_VALUE   = 8'h33;
    // Fixed byte count of the block registers
    localparam logic [7:0] BLOCK_COUNT       = 8'h01;
    // Word count of a plain word write
    localparam logic [7:0] WORD_COUNT        = 8'h02;

    // Comm fault bit positions
    localparam int         CF_BAD_CMD        = 7;
    localparam int         CF_BAD_DATA       = 6;
    localparam int         CF_PEC            = 5;
    // Reset values of comm and vendor status
    localparam logic [2:0] COMM_RESET        = 3'h0;
    localparam logic [6:0] VEND_RESET        = 7'h00;

    // Command request from the transaction engine
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] cmd;
        logic [7:0] count;
        logic [15:0] data;
    } pmr_req_t;

    // Answer to a request
    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [15:0] data;
    } pmr_rsp_t;

    // Raw measurements from the front end
    typedef struct packed {
        logic [10:0] vin;
        logic [10:0] iin;
        logic [15:0] vout;
        logic [10:0] iout;
        logic [10:0] temp;
        logic [10:0] freq;
    } pmr_tele_t;

    // Identification bytes handed to nonvolatile storage
    typedef struct packed {
        logic       valid;
        logic [7:0] maker;
        logic [7:0] model;
        logic [7:0] revision;
        logic [7:0] serial;
    } pmr_nvm_t;
endpackage : pmr_pkg

// ===== test/pmr_host_model.sv
`timescale 1ns/1ps
// Host side of the command link: one request, then its answer
module pmr_host_model (
    input  wire logic              clock_i, // Device clock
    output pmr_pkg::pmr_req_t      req_o,   // Request towards the bank
    input  wire pmr_pkg::pmr_rsp_t rsp_i    // Answer from the bank
);
    // Idle until the first request
    initial req_o = '0;

    // any command, block or word transfer
    // Caller passes count one for identification block writes, zero for their reads
    task automatic issue(input logic w, input logic [7:0] c, input logic [7:0] n,
                         input logic [15:0] d, output pmr_pkg::pmr_rsp_t r);
        @(posedge clock_i);
        #1;
        req_o = '{valid: 1'b1, write: w, cmd: c, count: n, data: d};
        @(posedge clock_i);
        #1;
        r = rsp_i;
        // Released lines show junk, so stale data cannot pass
        req_o.valid = 1'b0;
        req_o.data  = ~req_o.data;
        req_o.count = ~req_o.count;
    endtask : issue
endmodule : pmr_host_model

// ===== test/tb_pmbus_status_telemetry_id_regs.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    $display("[ERR] %s exp %h got %h", nm, ex, got); fails++; end end

module tb_pmbus_status_telemetry_id_regs;
    // Request beside its expected answer
    typedef struct packed {
        logic        w;
        logic [7:0]  c;
        logic [7:0]  n;
        logic [15:0] d;
        logic        ack;
        logic [15:0] q;
    } pmr_row_t;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] SERIAL = 8'h6d; // Arbitrary value
    logic                clock_i;
    logic                reset_n_i;
    pmr_pkg::pmr_req_t   req;
    pmr_pkg::pmr_rsp_t   rsp;
    pmr_pkg::pmr_nvm_t   nvm;
    logic                pec, clr, save, reg_on;
    logic [7:1]          vend;
    logic                summary, alert_n;
    int                  fails, tests_run, cycles;
    // Telemetry raw values; expected words add the fixed exponents, except output voltage
    pmr_pkg::pmr_tele_t  tele = '{11'h0c0, 11'h060, 16'h0200, 11'h0a0, 11'h7ec, 11'h0c8};
    pmr_row_t rows [18] = '{
        '{1'b0, 8'h98, 8'h00, 16'h0000, 1'b1, 16'h0033},
        '{1'b1, 8'h98, 8'h01, 16'h4400, 1'b0, 16'h0000},
        '{1'b0, 8'h98, 8'h00, 16'h0000, 1'b1, 16'h0033},
        '{1'b0, 8'h88, 8'h00, 16'h0000, 1'b1, 16'hd8c0},
        '{1'b0, 8'h89, 8'h00, 16'h0000, 1'b1, 16'he060},
        '{1'b0, 8'h8b, 8'h00, 16'h0000, 1'b1, 16'h0200},
        '{1'b0, 8'h8c, 8'h00, 16'h0000, 1'b1, 16'he0a0},
        '{1'b0, 8'h8d, 8'h00, 16'h0000, 1'b1, 16'h07ec},
        '{1'b0, 8'h95, 8'h00, 16'h0000, 1'b1, 16'h00c8},
        '{1'b0, 8'h99, 8'h00, 16'h0000, 1'b1, {MAKER, 8'h01}},
        '{1'b1, 8'h9a, 8'h01, 16'hc300, 1'b1, 16'h0000},
        '{1'b0, 8'h9a, 8'h00, 16'h0000, 1'b1, 16'hc301},
        '{1'b1, 8'h9b, 8'h01, 16'h7700, 1'b1, 16'h0000},
        '{1'b0, 8'h9b, 8'h00, 16'h0000, 1'b1, 16'h7701},
        '{1'b1, 8'h9e, 8'h01, 16'h1100, 1'b1, 16'h0000},
        '{1'b0, 8'h9e, 8'h00, 16'h0000, 1'b1, 16'h1101},
        '{1'b1, 8'h99, 8'h02, 16'h9900, 1'b0, 16'h0000},
        '{1'b0, 8'h7e, 8'h00, 16'h0000, 1'b1, 16'h00c0}
    };

    pmr_host_model host (.clock_i(clock_i), .req_o(req), .rsp_i(rsp));

    pmr_regs #(.MAKER_INIT(MAKER), .SERIAL_INIT(SERIAL)) dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req), .pec_error_i(pec),
        .clear_faults_i(clr), .save_all_i(save), .regulating_i(reg_on),
        .vendor_fault_i(vend), .tele_i(tele), .rsp_o(rsp), .nvm_o(nvm),
        .summary_comm_o(summary), .alert_output_low_o(alert_n));

    // Free-running device clock
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Hang guard, well above the expected run
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    // One request; data checked only on accepted reads
    task automatic run(input pmr_row_t rw);
        pmr_pkg::pmr_rsp_t r;
        host.issue(rw.w, rw.c, rw.n, rw.d, r);
        `CHK("valid", 1'b1, r.valid)
        `CHK("ack", rw.ack, r.ack)
        if (rw.ack && !rw.w) `CHK("data", rw.q, r.data)
    endtask : run

    // One-cycle pulse on a control input
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    // Verdict and end of run
    task automatic conclude();
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        {pec, clr, save, vend} = '0;
        reg_on = 1'b1;
        repeat (20) @(posedge clock_i);
        #1;
        `CHK("rst_rsp", 18'h0, rsp)
        `CHK("rst_alert", 1'b1, alert_n)
        `CHK("rst_sum", 1'b0, summary)
        reset_n_i = 1'b1;
        for (int i = 0; i < 18; i++) run(rows[i]);
        // Row tags continue
        tick(2);
        `CHK("sum", 1'b1, summary)
        `CHK("alert", 1'b0, alert_n)
        pulse(clr);
        run('{1'b0, 8'h7e, 8'h00, 16'h0, 1'b1, 16'h0000});
        run('{1'b0, 8'h55, 8'h00, 16'h0, 1'b0, 16'h0000});
        pulse(clr);
        pulse(pec);
        run('{1'b0, 8'h7e, 8'h00, 16'h0, 1'b1, 16'h0020});
        pulse(clr);
        // Mask the packet error, then raise one
        run('{1'b1, 8'h1b, 8'h02, 16'h207e, 1'b1, 16'h0});
        pulse(pec);
        tick(3);
        `CHK("masked", 1'b1, alert_n)
        `CHK("sum_m", 1'b1, summary)
        pulse(clr);
        vend = 7'h01;
        tick(6);
        run('{1'b0, 8'h80, 8'h00, 16'h0, 1'b1, 16'h0002});
        `CHK("v_alert", 1'b0, alert_n)
        vend = '0;
        reg_on = 1'b0;
        tick(4);
        run('{1'b0, 8'h89, 8'h00, 16'h0, 1'b0, 16'h0});
        run('{1'b0, 8'h8b, 8'h00, 16'h0, 1'b0, 16'h0});
        run('{1'b0, 8'h8c, 8'h00, 16'h0, 1'b0, 16'h0});
        run('{1'b0, 8'h95, 8'h00, 16'h0, 1'b0, 16'h0});
        run('{1'b0, 8'h88, 8'h00, 16'h0, 1'b1, 16'hd8c0});
        // Mask the vendor bit, then packet error and clear together
        run('{1'b1, 8'h1b, 8'h02, 16'h0280, 1'b1, 16'h0});
        tick(2);
        `CHK("v_mask", 1'b1, alert_n)
        {pec, clr} = 2'b11;
        tick(1);
        {pec, clr} = 2'b00;
        run('{1'b0, 8'h7e, 8'h00, 16'h0, 1'b1, 16'h0020});
        run('{1'b1, 8'h1b, 8'h02, 16'h0079, 1'b0, 16'h0});
        run('{1'b0, 8'h7e, 8'h00, 16'h0, 1'b1, 16'h0060});
        `CHK("alert2", 1'b0, alert_n)
        tick(1);
        save = 1'b1;
        tick(1);
        save = 1'b0;
        `CHK("nvm", {1'b1, MAKER, 8'hc3, 8'h77, 8'h11}, nvm)
        // Reset again in mid-run: status, alert and identity bytes return
        reset_n_i = 1'b0;
        tick(2);
        `CHK("rst2_alert", 1'b1, alert_n)
        `CHK("rst2_sum", 1'b0, summary)
        reset_n_i = 1'b1;
        run('{1'b0, 8'h9e, 8'h00, 16'h0, 1'b1, {SERIAL, 8'h01}});
        run('{1'b0, 8'h7e, 8'h00, 16'h0, 1'b1, 16'h0000});
        conclude();
    end
endmodule : tb_pmbus_status_telemetry_id_regs
